// ===== design/sysctl_pkg.sv
// package for the system control and clock select block
// assumes a single clock domain and an 8-bit special register port
package sysctl_pkg;
    // -----------------------------------------------------------------
    // register select codes
    // -----------------------------------------------------------------
    localparam logic [0:0] SEL_CTRL_A = 1'h0;
    localparam logic [0:0] SEL_CTRL_B = 1'h1;
    // -----------------------------------------------------------------
    // system_control_a fields
    // -----------------------------------------------------------------
    localparam int A_CLOCK_MODE = 0;
    localparam int A_CRYSTAL_POWER = 1;
    localparam int A_DIV_PIN_FUNC = 2;
    localparam int A_PWM_OUT = 3;
    localparam int A_PWM_TYPE = 5;
    localparam int A_DIV_CLK_SRC = 6;
    localparam logic [7:0] A_MASK_FULL = 8'h6f;
    localparam logic [7:0] A_MASK_LITE = 8'h47;
    localparam logic [7:0] A_RESET = 8'h00;
    // -----------------------------------------------------------------
    // system_control_b fields
    // -----------------------------------------------------------------
    localparam int B_WDT_LSB = 0;
    localparam int B_TICK_LSB = 4;
    localparam int B_EDGE_LSB = 6;
    localparam logic [7:0] B_RESET = 8'h8a;
    localparam logic [3:0] WDT_OFF_CODE = 4'ha;
    localparam logic [3:0] WDT_ON_CODE = 4'h5;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int TICK_BASE_LOG2 = 10;
    // -----------------------------------------------------------------
    // oscillator configuration options
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_EXT_FAST_CRYSTAL,
        OSC_EXT_RC,
        OSC_INTERNAL_FAST_RC,
        OSC_INTERNAL_FAST_RC_SLOW_CRYSTAL
    } osc_cfg_e;
endpackage

// ===== design/system_control_clock_select.sv
// system control registers: clock select, divider, edges, tick, watchdog
// assumes a core writes through a one-cycle strobe and reads combinationally
//
// Behaviour
// - divider clock source bit picks timer 0 when 0, timer 1 when 1.
// - divider pin bit gives general io at 0, divider output at 1.
// - crystal power bit: quick start-up at 0, low power at 1.
// - clock mode 0 runs the system clock from internal fast rc.
// - clock mode 1 runs from slow crystal and stops the fast rc.
// - clock mode bit only acts in fast rc plus slow crystal option.
// - unimplemented bits of first register read zero.
// - edge field: 00 off, 01 rising, 10 falling, 11 both.
// - tick field picks period of 2^10 to 2^13 tick clocks.
// - watchdog off only if option off and field is 1010.
// - always-on option ignores the field and keeps watchdog running.
// - oscillators also clock the watchdog and the time base.
// - external rc uses only pin one on port bit 6; bit 5 free.
// - internal fast rc frees port bits 5 and 6 as io.
// - slow crystal only allowed with internal fast rc.
// - sleep stops the system clock; slow clock keeps timers running.
// - crystal power bit clears at power-on for quick start-up.
// - sleep always stops the fast clock; slow crystal keeps running.
`timescale 1ns/1ps
module system_control_clock_select
    import sysctl_pkg::*;
#(
    parameter bit HAS_PWM = 1'b1,
    parameter osc_cfg_e OSC_CFG = OSC_INTERNAL_FAST_RC_SLOW_CRYSTAL,
    parameter bit WDT_OPTION_ON = 1'b0,
    parameter int TICK_MAX_LOG2 = 13
)
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // register port
    input wire logic i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // oscillator status and sleep
    input wire logic i_sleep,
    input wire logic i_fast_clk_tick,
    input wire logic i_slow_clk_tick,
    input wire logic i_slow_rc_tick,
    // timer sources and external interrupt pin
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_ext_int_pin,
    // clock control outputs
    output logic o_fast_rc_enable,
    output logic o_sys_clk_slow,
    output logic o_sys_clk_enable,
    output logic o_slow_crystal_enable,
    output logic o_crystal_low_power,
    // pin sharing
    output logic o_port_a_bit5_is_io,
    output logic o_port_a_bit6_is_io,
    output logic o_divider_on_pin,
    output logic o_divider_src_timer1,
    output logic o_divider_clk,
    // pwm control held for the pwm block
    output logic o_pwm_on_pin,
    output logic o_pwm_type,
    // events and watchdog
    output logic o_ext_int_event,
    output logic o_tick_event,
    output logic o_watchdog_run,
    output logic o_watchdog_clk
);
    // -----------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------
    if (TICK_MAX_LOG2 != TICK_BASE_LOG2 + 3)
    begin : g_bad_tick
        $error("tick counter width must cover four period codes");
    end

    localparam logic [7:0] A_MASK = HAS_PWM ? A_MASK_FULL : A_MASK_LITE;
    localparam bit SLOW_XTAL_CFG = (OSC_CFG == OSC_INTERNAL_FAST_RC_SLOW_CRYSTAL);

    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [TICK_MAX_LOG2-1:0] tick_cnt_q;
    logic tick_q;
    logic int_pin_q;
    logic int_evt_q;
    logic div_q;

    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_a_q <= A_RESET;
        end
        else if (i_reg_wr && i_reg_sel == SEL_CTRL_A)
        begin
            ctrl_a_q <= i_reg_wdata & A_MASK;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_b_q <= B_RESET;
        end
        else if (i_reg_wr && i_reg_sel == SEL_CTRL_B)
        begin
            ctrl_b_q <= i_reg_wdata;
        end
    end

    // unmasked storage is never nonzero, so reads are plain
    assign o_reg_rdata = (i_reg_sel == SEL_CTRL_A) ? ctrl_a_q : ctrl_b_q;

    // -----------------------------------------------------------------
    // clock selection and sleep
    // -----------------------------------------------------------------
    logic slow_mode;
    assign slow_mode = SLOW_XTAL_CFG && ctrl_a_q[A_CLOCK_MODE];
    assign o_sys_clk_slow = slow_mode;
    // fast rc is stopped in slow mode and always in sleep
    assign o_fast_rc_enable = (OSC_CFG == OSC_INTERNAL_FAST_RC || SLOW_XTAL_CFG)
                              && !slow_mode && !i_sleep;
    assign o_sys_clk_enable = !i_sleep;
    // slow crystal runs regardless of sleep once configured
    assign o_slow_crystal_enable = SLOW_XTAL_CFG;
    assign o_crystal_low_power = ctrl_a_q[A_CRYSTAL_POWER];

    // -----------------------------------------------------------------
    // pin sharing
    // -----------------------------------------------------------------
    assign o_port_a_bit5_is_io = (OSC_CFG == OSC_EXT_RC)
                                 || (OSC_CFG == OSC_INTERNAL_FAST_RC);
    assign o_port_a_bit6_is_io = (OSC_CFG == OSC_INTERNAL_FAST_RC);
    assign o_divider_on_pin = ctrl_a_q[A_DIV_PIN_FUNC];
    assign o_divider_src_timer1 = ctrl_a_q[A_DIV_CLK_SRC];
    assign o_pwm_on_pin = ctrl_a_q[A_PWM_OUT];
    assign o_pwm_type = ctrl_a_q[A_PWM_TYPE];

    // -----------------------------------------------------------------
    // programmable divider: toggles on each selected timer overflow
    // -----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            div_q <= 1'b0;
        end
        else if (o_divider_src_timer1 ? i_timer1_ovf : i_timer0_ovf)
        begin
            div_q <= !div_q;
        end
    end
    assign o_divider_clk = div_q;

    // -----------------------------------------------------------------
    // external interrupt edge detect
    // -----------------------------------------------------------------
    logic [1:0] edge_sel;
    logic rise;
    logic fall;
    assign edge_sel = ctrl_b_q[B_EDGE_LSB +: 2];
    assign rise = i_ext_int_pin && !int_pin_q;
    assign fall = !i_ext_int_pin && int_pin_q;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            int_pin_q <= 1'b0;
            int_evt_q <= 1'b0;
        end
        else
        begin
            int_pin_q <= i_ext_int_pin;
            unique case (edge_sel)
                EDGE_OFF: int_evt_q <= 1'b0;
                EDGE_RISE: int_evt_q <= rise;
                EDGE_FALL: int_evt_q <= fall;
                EDGE_BOTH: int_evt_q <= rise || fall;
            endcase
        end
    end
    assign o_ext_int_event = int_evt_q;

    // -----------------------------------------------------------------
    // time base: tick clock follows system clock source, slow in sleep
    // -----------------------------------------------------------------
    localparam int TICK_W = TICK_MAX_LOG2 + 1;
    localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
    logic tb_clk;
    logic [TICK_W-1:0] tick_span;
    logic [TICK_MAX_LOG2-1:0] tick_last;
    assign tb_clk = (slow_mode || i_sleep) ? i_slow_clk_tick : i_fast_clk_tick;
    // period = 2^(10+code); one spare bit keeps the longest span from wrapping
    assign tick_span = (TICK_ONE << (TICK_BASE_LOG2 + int'(ctrl_b_q[B_TICK_LSB +: 2])))
                       - TICK_ONE;
    assign tick_last = tick_span[TICK_MAX_LOG2-1:0];

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (tb_clk)
            begin
                if (tick_cnt_q >= tick_last)
                begin
                    tick_cnt_q <= '0;
                    tick_q <= 1'b1;
                end
                else
                begin
                    tick_cnt_q <= tick_cnt_q + 1'b1;
                end
            end
        end
    end
    assign o_tick_event = tick_q;

    // -----------------------------------------------------------------
    // watchdog enable; code 0101 recommended but any non-1010 runs it
    // -----------------------------------------------------------------
    assign o_watchdog_run = WDT_OPTION_ON
                            || (ctrl_b_q[B_WDT_LSB +: 4] != WDT_OFF_CODE);
    // watchdog counts on the free slow rc, so it survives sleep
    assign o_watchdog_clk = i_slow_rc_tick && o_watchdog_run;

endmodule // system_control_clock_select

// ===== dv/sysctl_chk.sv
// checker: port assertions for the system control block
// assumes a bind from the bench top file, default parameters on the design
`timescale 1ns/1ps
module sysctl_chk
    import sysctl_pkg::*;
(
    // clock, reset and register port
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // status inputs and outputs watched
    input wire logic i_sleep,
    input wire logic i_slow_rc_tick,
    input wire logic i_ext_int_pin,
    input wire logic o_fast_rc_enable,
    input wire logic o_sys_clk_slow,
    input wire logic o_sys_clk_enable,
    input wire logic o_crystal_low_power,
    input wire logic o_divider_on_pin,
    input wire logic o_ext_int_event,
    input wire logic o_tick_event,
    input wire logic o_watchdog_run,
    input wire logic o_watchdog_clk
);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence b_write;
        i_reg_wr && i_reg_sel;
    endsequence
    sequence a_write;
        i_reg_wr && !i_reg_sel;
    endsequence
    read_zero_a: assert property (!i_reg_sel |-> (o_reg_rdata & ~A_MASK_FULL) == 0)
        else $error("unimplemented bits read nonzero");
    wdt_code_a: assert property (b_write |=>
        o_watchdog_run == (($past(i_reg_wdata) & 8'h0f) != 8'h0a)) else $error("watchdog run wrong");
    mode_write_a: assert property (a_write |=>
        o_sys_clk_slow == (($past(i_reg_wdata) & 8'h01) != 0)) else $error("clock mode wrong");
    fast_rc_a: assert property (o_fast_rc_enable == (!o_sys_clk_slow && !i_sleep))
        else $error("fast rc enable wrong");
    sleep_clk_a: assert property (o_sys_clk_enable == !i_sleep)
        else $error("system clock not stopped in sleep");
    xtal_quick_a: assert property ($rose(i_reset_n) |-> !o_crystal_low_power)
        else $error("crystal power not cleared");
    edge_cause_a: assert property (o_ext_int_event |->
        $past(i_ext_int_pin) != $past(i_ext_int_pin, 2)) else $error("event without pin edge");
    tick_pulse_a: assert property (o_tick_event |=> !o_tick_event)
        else $error("tick event longer than one cycle");
    wdt_clock_a: assert property (o_watchdog_clk == (i_slow_rc_tick && o_watchdog_run))
        else $error("watchdog clock wrong");
    div_pin_a: assert property (a_write |=> o_divider_on_pin == $past(i_reg_wdata[2]))
        else $error("divider pin select wrong");
endmodule // sysctl_chk

// ===== dv/system_control_clock_select_tb.sv
// bench: drives the register port and status pulses, compares with a model
// assumes default design parameters and the checker bound below
`timescale 1ns/1ps
module system_control_clock_select_tb;
    import sysctl_pkg::*;
    logic i_mclk = 0, i_reset_n = 0, i_reg_sel = 0, i_reg_wr = 0, i_sleep = 0;
    logic i_fast_clk_tick = 0, i_slow_clk_tick = 0, i_slow_rc_tick = 0, i_ext_int_pin = 0;
    logic i_timer0_ovf = 0, i_timer1_ovf = 0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    logic o_fast_rc_enable, o_sys_clk_slow, o_sys_clk_enable, o_slow_crystal_enable;
    logic o_crystal_low_power, o_port_a_bit5_is_io, o_port_a_bit6_is_io, o_divider_on_pin;
    logic o_divider_src_timer1, o_divider_clk, o_pwm_on_pin, o_pwm_type;
    logic o_ext_int_event, o_tick_event, o_watchdog_run, o_watchdog_clk;
    int n_mismatch = 0, num_checks = 0, a_m = 0, b_m = 'h8a, n_ev = 0, n_tk = 0;
    system_control_clock_select dut_u (.i_mclk, .i_reset_n, .i_reg_sel, .i_reg_wr,
        .i_reg_wdata, .o_reg_rdata, .i_sleep, .i_fast_clk_tick, .i_slow_clk_tick,
        .i_slow_rc_tick, .i_timer0_ovf, .i_timer1_ovf, .i_ext_int_pin, .o_fast_rc_enable,
        .o_sys_clk_slow, .o_sys_clk_enable, .o_slow_crystal_enable, .o_crystal_low_power,
        .o_port_a_bit5_is_io, .o_port_a_bit6_is_io, .o_divider_on_pin, .o_divider_src_timer1,
        .o_divider_clk, .o_pwm_on_pin, .o_pwm_type, .o_ext_int_event, .o_tick_event,
        .o_watchdog_run, .o_watchdog_clk);
    // ---------------------------------------------------------------
    // clock, counters and tasks
    // ---------------------------------------------------------------
    initial forever #2.5 i_mclk = ~i_mclk;
    // counted on the falling edge, where the pulses have settled
    always @(negedge i_mclk) n_ev += (o_ext_int_event === 1'b1);
    always @(negedge i_mclk) n_tk += (o_tick_event === 1'b1);
    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // idle cycle after each write keeps the strobe from being set twice in a step
    task automatic wr(input logic s, input logic [7:0] d);
        i_reg_sel = s;
        i_reg_wdata = d;
        i_reg_wr = 1;
        step;
        i_reg_wr = 0;
        if (s) b_m = d;
        else a_m = d & A_MASK_FULL;
        step;
    endtask
    task automatic check_all;
        i_reg_sel = 0;
        step;
        chk("reg_a", a_m[7:0], o_reg_rdata);
        i_reg_sel = 1;
        step;
        chk("reg_b", b_m[7:0], o_reg_rdata);
        chk("pwm_pin", a_m[3], o_pwm_on_pin);
        chk("pwm_type", a_m[5], o_pwm_type);
        chk("slow", a_m[0], o_sys_clk_slow);
        chk("fast_rc", !a_m[0] && !i_sleep, o_fast_rc_enable);
        chk("low_pwr", a_m[1], o_crystal_low_power);
        chk("div_pin", a_m[2], o_divider_on_pin);
        chk("div_src", a_m[6], o_divider_src_timer1);
        chk("wdt_run", b_m[3:0] != 4'ha, o_watchdog_run);
        chk("wdt_clk", i_slow_rc_tick && b_m[3:0] != 4'ha, o_watchdog_clk);
        chk("sys_en", !i_sleep, o_sys_clk_enable);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // run is a few thousand cycles, so this limit only trips on a hang
    initial
    begin
        #50000;
        n_mismatch++;
        stop_test;
    end
    initial
    begin
        void'($urandom(32'h7dee016d));
        repeat (10) @(posedge i_mclk);
        #1;
        i_reset_n = 1;
        step;
        check_all;
        chk("xtal_en", 1, o_slow_crystal_enable);
        chk("pins_io", 0, {o_port_a_bit5_is_io, o_port_a_bit6_is_io});
        for (int k = 0; k < 24; k++)
        begin
            i_sleep = k[0];
            i_slow_rc_tick = k[2];
            wr(k[1], 8'($urandom));
            check_all;
        end
        i_sleep = 0;
        // mid-run reset must bring both registers back to their power-on values
        i_reset_n = 0;
        step;
        i_reset_n = 1;
        a_m = 0;
        b_m = 'h8a;
        step;
        check_all;
        for (int e = 0; e < 4; e++)
        begin
            wr(1, {e[1:0], 2'b00, e[0] ? WDT_ON_CODE : WDT_OFF_CODE});
            check_all;
            n_ev = 0;
            repeat (2)
            begin
                i_ext_int_pin = 1;
                repeat (3) step;
                i_ext_int_pin = 0;
                repeat (3) step;
            end
            chk("edges", (e == 0) ? 0 : (e == 3) ? 4 : 2, n_ev);
        end
        wr(0, 8'h00);
        wr(1, 8'h00);
        i_timer1_ovf = 1;
        step;
        i_timer1_ovf = 0;
        step;
        chk("div_clk", 0, o_divider_clk);
        i_timer0_ovf = 1;
        step;
        i_timer0_ovf = 0;
        step;
        chk("div_clk", 1, o_divider_clk);
        wr(0, 8'h40);
        chk("div_src", 1, o_divider_src_timer1);
        i_timer0_ovf = 1;
        step;
        i_timer0_ovf = 0;
        step;
        chk("div_clk", 1, o_divider_clk);
        i_timer1_ovf = 1;
        step;
        i_timer1_ovf = 0;
        step;
        chk("div_clk", 0, o_divider_clk);
        n_tk = 0;
        i_fast_clk_tick = 1;
        repeat (1023) step;
        chk("tick_early", 0, n_tk);
        step;
        i_fast_clk_tick = 0;
        repeat (3) step;
        chk("tick", 1, n_tk);
        // code 01 in sleep: time base must run from the slow tick
        i_sleep = 1;
        wr(1, 8'h10);
        n_tk = 0;
        i_slow_clk_tick = 1;
        repeat (2047) step;
        chk("slow_tick_early", 0, n_tk);
        step;
        i_slow_clk_tick = 0;
        repeat (3) step;
        chk("slow_tick", 1, n_tk);
        stop_test;
    end
endmodule // system_control_clock_select_tb
bind system_control_clock_select sysctl_chk chk_u (.i_mclk, .i_reset_n, .i_reg_sel, .i_reg_wr,
    .i_reg_wdata, .o_reg_rdata, .i_sleep, .i_slow_rc_tick, .i_ext_int_pin, .o_fast_rc_enable,
    .o_sys_clk_slow, .o_sys_clk_enable, .o_crystal_low_power, .o_divider_on_pin,
    .o_ext_int_event, .o_tick_event, .o_watchdog_run, .o_watchdog_clk);
